//--- rtl/hpdc_host_port.sv
// host port control register, request line, dma address counter and data path
//
// Notes on behaviour
// - eight-bit control register, host side only
// - receive enable gates receive-full onto request
// - transmit enable gates transmit-empty onto request
// - dma: exactly one enable picks direction
// - bit two reads as zero
// - two host flags reach dsp status
// - mode field: interrupt, 24, 16, 8-bit dma
// - interrupt mode: acknowledge is vector acknowledge
// - dma: acknowledge drives or captures data byte
// - counter replaces low select bits, top forced
// - counter advances, reloads mode after low byte
// - init set by host, cleared when done
// - interrupt-mode init zeroes counter, clears channels
// - dma-mode init loads mode into counter
// - init waits for word transfer to finish
// - resets clear enables, flags, mode, init
// - receive-full sets on load, clears on low read
// - transmit-empty sets on move, clears low write
`timescale 1ns/1ns
module hpdc_host_port
   import hpdc_pkg::*;
(
   input  wire logic        clk,            // 25 MHz clock
   input  wire logic        nrst,           // asynchronous reset, active low
   input  wire logic        softResetN,     // software/individual/stop reset, active low
   input  wire logic        hostSelect,     // host register access strobe
   input  wire logic        hostWrite,      // 1 write, 0 read
   input  wire logic [2:0]  hostAddr,       // register select bits
   input  wire logic [7:0]  hostWrData,     // host data bus in
   input  wire logic        hostAckN,       // host_acknowledge_input, active low
   output logic      [7:0]  hostRdData,     // host data bus out
   output logic             hostDataOe,     // host data bus drive enable
   output logic             hostRequestN,   // host_request_line, active low
   output logic             vectorAck,      // interrupt acknowledge pulse
   output logic             hostFlagZero,   // flag bit to dsp status
   output logic             hostFlagOne,    // flag bit to dsp status
   input  wire logic        dspFlagTwo,     // dsp flag shown to host
   input  wire logic        dspFlagThree,   // dsp flag shown to host
   input  wire logic        dspTxValid,     // dsp offers a word to host
   input  wire logic [23:0] dspTxData,      // dsp word to host
   output logic             dspTxReady,     // buffer has room
   output logic             dspRxValid,     // dsp_side_receive_full
   output logic      [23:0] dspRxData,      // word from host
   input  wire logic        dspRxReady      // dsp takes the word
);

   // ------------------------------------------------------------------
   // reset synchroniser
   // ------------------------------------------------------------------
   logic       rstMeta;
   logic       rstSync;
   logic       rst;
   // two flops release the reset
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta <= 1'b0;
         rstSync <= 1'b0;
      end else begin
         rstMeta <= 1'b1;
         rstSync <= rstMeta;
      end
   end
   assign rst = !rstSync || !softResetN;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   logic        rxEnable;       // receive_request_enable
   logic        txEnable;       // transmit_request_enable
   logic [1:0]  modeSel;        // mode_select_high, mode_select_low
   logic        initBit;        // initialise command pending
   logic        rxFull;         // receive_full_flag
   logic        txEmpty;        // transmit_empty_flag
   logic [1:0]  addrCount;      // dma address counter
   logic        wordBusy;       // dma word partly moved
   logic        ackPrev;        // acknowledge seen last cycle
   logic [7:0]  rxByte [3];     // receive bytes high, mid, low
   logic [7:0]  txByte [3];     // transmit bytes high, mid, low
   logic [23:0] fifoMem [HPDC_FIFO_DEPTH];
   logic        fifoWrPtr;
   logic        fifoRdPtr;
   logic [1:0]  fifoCount;

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   logic       dmaMode;
   logic       ackActive;
   logic       ackStart;
   logic       ackEnd;
   logic       dmaAck;
   logic       dirRx;
   logic       dirTx;
   logic [2:0] effAddr;
   logic       effWrite;
   logic       accessHit;
   logic       ctrlWrite;
   logic       byteWrite;
   logic       lowRead;
   logic       lowWrite;
   logic       initRun;
   logic       initRx;
   logic       initTx;
   logic       moveRx;
   logic       moveTx;
   logic       fifoValid;
   logic       fifoPush;
   logic       fifoPop;
   logic [1:0] byteIdx;
   logic       reqLevel;
   logic [7:0] controlValue;
   logic [7:0] statusValue;
   logic [7:0] readMux;
   logic [1:0] next_addrCount;
   logic [1:0] next_fifoCount;
   assign dmaMode   = (modeSel != HPDC_MODE_INTR);
   assign ackActive = !hostAckN;
   assign ackStart  = ackActive && !ackPrev;
   assign ackEnd    = !ackActive && ackPrev;
   assign dmaAck    = dmaMode && ackActive;
   // direction from the single active enable
   assign dirRx     = rxEnable && !txEnable;
   assign dirTx     = txEnable && !rxEnable;
   // counter stands in for the low select bits
   assign effAddr   = dmaAck ? {1'b1, addrCount} : hostAddr;
   assign effWrite  = dmaAck ? dirTx : hostWrite;
   assign accessHit = dmaAck ? ackStart && (dirRx || dirTx) : hostSelect;
   // only the host bus reaches the control register
   assign ctrlWrite = accessHit && effWrite && (effAddr == HPDC_ADDR_CONTROL);
   assign byteWrite = accessHit && effWrite && effAddr[2] && (effAddr[1:0] != 2'h0);
   assign lowRead   = accessHit && !effWrite && (effAddr == HPDC_ADDR_LOW);
   assign lowWrite  = accessHit && effWrite && (effAddr == HPDC_ADDR_LOW);
   assign byteIdx   = effAddr[1:0] - 2'h1;
   // init held off while a dma word is moving
   assign initRun   = initBit && !(dmaMode && wordBusy) && !ackActive;
   // channel clears picked by the enables
   assign initRx    = initRun && rxEnable && !(dmaMode && txEnable);
   assign initTx    = initRun && txEnable && !(dmaMode && rxEnable);
   // buffer and channel moves
   assign fifoValid = (fifoCount != 2'h0);
   assign fifoPush  = dspTxValid && dspTxReady && !initRx;
   // dsp word loads the receive bytes
   assign moveRx    = fifoValid && !rxFull && !initRun && !dmaAck;
   assign fifoPop   = moveRx;
   // transmit bytes move to the dsp side
   assign moveTx    = !txEmpty && !dspRxValid && !initRun && !dmaAck;
   assign reqLevel  = dmaMode ? ((dirRx && rxFull) || (dirTx && txEmpty))
                              : ((rxEnable && rxFull) || (txEnable && txEmpty));
   assign controlValue = {initBit, modeSel, hostFlagOne, hostFlagZero, 1'b0,
                          txEnable, rxEnable};
   assign statusValue  = {!hostRequestN, dmaMode, 1'b0, dspFlagThree, dspFlagTwo,
                          txEmpty && !dspRxValid, txEmpty, rxFull};
   assign readMux = (effAddr == HPDC_ADDR_CONTROL) ? controlValue :
                    (effAddr == HPDC_ADDR_STATUS)  ? statusValue  :
                    (effAddr[2] && effAddr[1:0] != 2'h0) ? rxByte[byteIdx] : 8'h00;
   // advance or reload from the mode field
   assign next_addrCount = (addrCount == HPDC_COUNT_LAST) ? modeSel
                                                          : addrCount + 2'h1;
   assign next_fifoCount = fifoCount + {1'b0, fifoPush} - {1'b0, fifoPop};

   // ------------------------------------------------------------------
   // control register
   // ------------------------------------------------------------------
   // resets clear the writable fields
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         {initBit, modeSel, hostFlagOne, hostFlagZero} <= 5'h00;
         {txEnable, rxEnable}                          <= 2'h0;
      end else if (rst) begin
         {initBit, modeSel, hostFlagOne, hostFlagZero} <= 5'h00;
         {txEnable, rxEnable}                          <= 2'h0;
      end else if (ctrlWrite) begin
         // host flags from the host write
         rxEnable     <= hostWrData[HPDC_BIT_RX_ENABLE];
         txEnable     <= hostWrData[HPDC_BIT_TX_ENABLE];
         hostFlagZero <= hostWrData[HPDC_BIT_FLAG_ZERO];
         hostFlagOne  <= hostWrData[HPDC_BIT_FLAG_ONE];
         modeSel      <= {hostWrData[HPDC_BIT_MODE_HIGH], hostWrData[HPDC_BIT_MODE_LOW]};
         initBit      <= hostWrData[HPDC_BIT_INIT];
      end else if (initRun) begin
         initBit <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // dma address counter and word tracking
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addrCount <= HPDC_COUNT_RESET;
         wordBusy  <= 1'b0;
         ackPrev   <= 1'b0;
      end else if (rst) begin
         addrCount <= HPDC_COUNT_RESET;
         wordBusy  <= 1'b0;
         ackPrev   <= 1'b0;
      end else begin
         ackPrev <= ackActive;
         if (initRun) begin
            addrCount <= dmaMode ? modeSel : HPDC_COUNT_RESET;
            wordBusy  <= 1'b0;
         end else if (dmaMode && ackEnd) begin
            addrCount <= next_addrCount;
            wordBusy  <= (addrCount != HPDC_COUNT_LAST);
         end
      end
   end

   // ------------------------------------------------------------------
   // host side flags
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rxFull  <= 1'b0;
         txEmpty <= 1'b1;
      end else if (rst) begin
         rxFull  <= 1'b0;
         txEmpty <= 1'b1;
      end else begin
         // load sets, low byte read clears
         if (initRx || lowRead)
            rxFull <= 1'b0;
         if (moveRx)
            rxFull <= 1'b1;
         // move sets, low byte write clears
         if (lowWrite)
            txEmpty <= 1'b0;
         if (moveTx || initTx)
            txEmpty <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // data byte registers
   // ------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_byte
         // capture or load one byte lane
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               rxByte[gi] <= 8'h00;
               txByte[gi] <= 8'h00;
            end else begin
               if (moveRx)
                  rxByte[gi] <= fifoMem[fifoRdPtr][23-8*gi -: 8];
               if (byteWrite && byteIdx == 2'(gi))
                  txByte[gi] <= hostWrData;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // two-entry buffer from dsp to host
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (fifoPush)
         fifoMem[fifoWrPtr] <= dspTxData;
   end
   // pointers, count and registered ready
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fifoWrPtr  <= 1'b0;
         fifoRdPtr  <= 1'b0;
         fifoCount  <= 2'h0;
         dspTxReady <= 1'b0;
      end else if (rst || initRx) begin
         // receive init empties the dsp transmit side
         fifoWrPtr  <= 1'b0;
         fifoRdPtr  <= 1'b0;
         fifoCount  <= 2'h0;
         dspTxReady <= !rst;
      end else begin
         if (fifoPush)
            fifoWrPtr <= !fifoWrPtr;
         if (fifoPop)
            fifoRdPtr <= !fifoRdPtr;
         fifoCount  <= next_fifoCount;
         dspTxReady <= (next_fifoCount != HPDC_FIFO_FULL);
      end
   end

   // ------------------------------------------------------------------
   // dsp receive register
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dspRxValid <= 1'b0;
         dspRxData  <= 24'h00_0000;
      end else if (rst || initTx) begin
         dspRxValid <= 1'b0;
      end else if (moveTx) begin
         dspRxValid <= 1'b1;
         dspRxData  <= {txByte[0], txByte[1], txByte[2]};
      end else if (dspRxReady) begin
         dspRxValid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // host bus outputs and request line
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hostRdData   <= 8'h00;
         hostDataOe   <= 1'b0;
         hostRequestN <= 1'b1;
         vectorAck    <= 1'b0;
      end else if (rst) begin
         hostRdData   <= 8'h00;
         hostDataOe   <= 1'b0;
         hostRequestN <= 1'b1;
         vectorAck    <= 1'b0;
      end else begin
         // drive the selected byte during host or dma read
         if (accessHit && !effWrite)
            hostRdData <= readMux;
         hostDataOe   <= (hostSelect && !hostWrite) || (dmaAck && dirRx);
         hostRequestN <= !reqLevel;
         vectorAck    <= !dmaMode && ackStart;
      end
   end

endmodule // hpdc_host_port

//--- rtl/hpdc_pkg.sv
// constants for the host port request and dma control block
package hpdc_pkg;

   // ------------------------------------------------------------------
   // register select codes on the host side
   // ------------------------------------------------------------------
   localparam logic [2:0] HPDC_ADDR_CONTROL = 3'h0;   // host_interrupt_control
   localparam logic [2:0] HPDC_ADDR_STATUS  = 3'h2;   // host_side_status
   localparam logic [2:0] HPDC_ADDR_HIGH    = 3'h5;   // high data byte
   localparam logic [2:0] HPDC_ADDR_MID     = 3'h6;   // middle data byte
   localparam logic [2:0] HPDC_ADDR_LOW     = 3'h7;   // low data byte

   // ------------------------------------------------------------------
   // control register field positions
   // ------------------------------------------------------------------
   localparam int HPDC_BIT_RX_ENABLE = 0;   // receive_request_enable
   localparam int HPDC_BIT_TX_ENABLE = 1;   // transmit_request_enable
   localparam int HPDC_BIT_FLAG_ZERO = 3;   // host_flag_zero
   localparam int HPDC_BIT_FLAG_ONE  = 4;   // host_flag_one
   localparam int HPDC_BIT_MODE_LOW  = 5;   // mode_select_low
   localparam int HPDC_BIT_MODE_HIGH = 6;   // mode_select_high
   localparam int HPDC_BIT_INIT      = 7;   // initialise command

   // ------------------------------------------------------------------
   // status register field positions
   // ------------------------------------------------------------------
   localparam int HPDC_STAT_RX_FULL  = 0;
   localparam int HPDC_STAT_TX_EMPTY = 1;
   localparam int HPDC_STAT_TX_READY = 2;
   localparam int HPDC_STAT_FLAG_TWO = 3;
   localparam int HPDC_STAT_FLAG_THR = 4;
   localparam int HPDC_STAT_DMA      = 6;
   localparam int HPDC_STAT_REQUEST  = 7;

   // ------------------------------------------------------------------
   // reset values and codes
   // ------------------------------------------------------------------
   localparam logic [7:0] HPDC_CONTROL_RESET = 8'h00;
   localparam logic [1:0] HPDC_MODE_INTR     = 2'h0;   // interrupt mode, dma off
   localparam logic [1:0] HPDC_COUNT_LAST    = 2'h3;   // low byte register
   localparam logic [1:0] HPDC_COUNT_RESET   = 2'h0;
   localparam int         HPDC_FIFO_DEPTH    = 2;
   localparam logic [1:0] HPDC_FIFO_FULL     = 2'h2;

endpackage

//--- test/hpdc_host_model.sv
// host processor and dma controller model
`timescale 1ns/1ns
module hpdc_host_model (
   input  wire logic       clk,        // clock
   input  wire logic [7:0] hostRdData, // read data
   output logic            hostSelect, // strobe
   output logic            hostWrite,  // write
   output logic      [2:0] hostAddr,   // select
   output logic      [7:0] hostWrData, // bus data
   output logic            hostAckN    // ack, active low
);
   // idle bus at time zero
   initial begin
      hostSelect = 1'b0;
      hostWrite  = 1'b0;
      hostAddr   = 3'h0;
      hostWrData = 8'h00;
      hostAckN   = 1'b1;
   end
   // one access, released after its taking edge
   task automatic access(input logic w, input logic [2:0] a, input logic [7:0] d,
                         output logic [7:0] q);
      @(posedge clk);
      #2;
      hostSelect = 1'b1;
      hostWrite  = w;
      hostAddr   = a;
      hostWrData = d;
      @(posedge clk);
      #2;
      q          = hostRdData;
      hostSelect = 1'b0;
      hostWrData = ~hostWrData;
      hostAddr   = ~hostAddr;
   endtask
   // bytes held while ack low, no address given
   task automatic dma(input int n, input logic [23:0] w, output logic [23:0] q);
      q = 24'h00_0000;
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk);
         #2;
         hostAckN   = 1'b0;
         hostWrData = w[8*i +: 8];
         repeat (2) @(posedge clk);
         #2;
         q          = {q[15:0], hostRdData};
         hostAckN   = 1'b1;
         hostWrData = ~hostWrData;
      end
   endtask
endmodule // hpdc_host_model

//--- test/hpdc_host_port_props.sv
// checker for the host port block
`timescale 1ns/1ns
module hpdc_host_port_props (
   input wire logic       clk,          // clock
   input wire logic       nrst,         // reset
   input wire logic       softResetN,   // sync reset
   input wire logic       hostSelect,   // strobe
   input wire logic       hostWrite,    // write
   input wire logic [2:0] hostAddr,     // select
   input wire logic [7:0] hostWrData,   // data in
   input wire logic       hostAckN,     // ack
   input wire logic [7:0] hostRdData,   // data out
   input wire logic       hostDataOe,   // drive
   input wire logic       hostRequestN, // request
   input wire logic       vectorAck,    // vector ack
   input wire logic       hostFlagZero, // flag
   input wire logic       hostFlagOne   // flag
);
   // accesses the block takes
   wire rdOk  = hostSelect && !hostWrite && hostAckN && softResetN;
   wire wrCtl = hostSelect && hostWrite && hostAddr == 3'h0 && hostAckN && softResetN;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // ------------------------------------------------------------------
   // properties
   // ------------------------------------------------------------------
   property p_resBit; rdOk && hostAddr == 3'h0 |=> !hostRdData[2]; endproperty
   a_resBit: assert property (p_resBit) else $error("reserved bit high");
   property p_unmap; rdOk && hostAddr inside {3'h1, 3'h3, 3'h4} |=> hostRdData == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_flags; wrCtl ##1 !wrCtl && softResetN
      |=> {hostFlagOne, hostFlagZero} == $past(hostWrData[4:3], 2); endproperty
   a_flags: assert property (p_flags) else $error("host flags wrong");
   property p_reqOff; wrCtl && hostWrData[1:0] == 2'h0 ##1 !wrCtl && softResetN
      |=> hostRequestN; endproperty
   a_reqOff: assert property (p_reqOff) else $error("request without enable");
   property p_both; wrCtl && hostWrData[1:0] == 2'h3 && hostWrData[6:5] != 2'h0
      ##1 !wrCtl && softResetN |=> hostRequestN; endproperty
   a_both: assert property (p_both) else $error("request with both enables");
   property p_vack; vectorAck |-> !$past(hostAckN) && $past(hostAckN, 2); endproperty
   a_vack: assert property (p_vack) else $error("vector ack without ack edge");
   property p_vackOne; vectorAck |=> !vectorAck; endproperty
   a_vackOne: assert property (p_vackOne) else $error("vector ack too long");
   property p_oeRead; rdOk |=> hostDataOe; endproperty
   a_oeRead: assert property (p_oeRead) else $error("read not driven");
   property p_oeIdle; !hostSelect && hostAckN |=> !hostDataOe; endproperty
   a_oeIdle: assert property (p_oeIdle) else $error("bus driven when idle");
   property p_soft; !softResetN |=> hostRequestN && !hostFlagZero && !hostFlagOne; endproperty
   a_soft: assert property (p_soft) else $error("soft reset incomplete");
   // main scenarios seen
   c_vack: cover property (vectorAck);
   c_dmaRd: cover property (hostDataOe && !hostAckN);
   c_req: cover property ($fell(hostRequestN));
endmodule // hpdc_host_port_props

bind hpdc_host_port hpdc_host_port_props u_props (.clk, .nrst, .softResetN, .hostSelect,
   .hostWrite, .hostAddr, .hostWrData, .hostAckN, .hostRdData, .hostDataOe, .hostRequestN,
   .vectorAck, .hostFlagZero, .hostFlagOne);

//--- test/testbench.sv
// self-checking bench for the host port block
`timescale 1ns/1ns
`define CHK(n, e, v) begin checksDone++; if ((v) !== (e)) begin errorCnt++; \
   $display("BAD %s exp %h got %h", n, e, v); end end
module testbench
   import hpdc_pkg::*;
;
   logic        clk, nrst, softResetN, dspFlagTwo, dspFlagThree, dspTxValid, dspRxReady;
   logic        hostSelect, hostWrite, hostAckN, hostDataOe, hostRequestN, vectorAck;
   logic        hostFlagZero, hostFlagOne, dspTxReady, dspRxValid;
   logic [2:0]  hostAddr;
   logic [7:0]  hostWrData, hostRdData, s;
   logic [23:0] dspTxData, dspRxData, w;
   logic [23:0] words [3] = '{24'hAB_CDEF, 24'h34_5678, 24'h56_789A};
   int          errorCnt = 0, checksDone = 0, cycles = 0, vackCnt = 0;

   hpdc_host_port DUT (.clk, .nrst, .softResetN, .hostSelect, .hostWrite, .hostAddr,
      .hostWrData, .hostAckN, .hostRdData, .hostDataOe, .hostRequestN, .vectorAck,
      .hostFlagZero, .hostFlagOne, .dspFlagTwo, .dspFlagThree, .dspTxValid, .dspTxData,
      .dspTxReady, .dspRxValid, .dspRxData, .dspRxReady);
   hpdc_host_model host (.clk, .hostRdData, .hostSelect, .hostWrite, .hostAddr,
      .hostWrData, .hostAckN);

   // ------------------------------------------------------------------
   // clock, timeout, monitors and tasks
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(negedge clk) begin
      cycles++;
      if (vectorAck === 1'b1) vackCnt++;
      if (cycles == 6000) begin
         errorCnt++;
         endSim();
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] q;
      host.access(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [2:0] a);
      host.access(1'b0, a, 8'h00, s);
   endtask
   task automatic wrWord(input logic [23:0] d);
      for (int i = 5; i <= 7; i++) wr(i[2:0], d[8*(7-i) +: 8]);
   endtask
   task automatic rdWord(output logic [23:0] q);
      q = 24'h00_0000;
      for (int i = 5; i <= 7; i++) begin
         rd(i[2:0]);
         q = {q[15:0], s};
      end
   endtask
   // dsp offers a word, held until the buffer takes it
   task automatic push(input logic [23:0] d);
      @(posedge clk);
      #2;
      dspTxValid = 1'b1;
      dspTxData  = d;
      while (dspTxReady !== 1'b1) tick(1);
      tick(1);
      dspTxValid = 1'b0;
      dspTxData  = ~d;
   endtask
   task automatic endSim();
      $display("checks %0d errors %0d", checksDone, errorCnt);
      if (errorCnt == 0 && checksDone > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------------
   initial begin
      nrst = 1'b0;
      softResetN = 1'b1;
      dspFlagTwo = 1'b1;
      dspFlagThree = 1'b0;
      dspTxValid = 1'b0;
      dspTxData = 24'h00_0000;
      dspRxReady = 1'b0;
      tick(8);
      nrst = 1'b1;
      tick(4);
      `CHK("txReady", 1'b1, dspTxReady)
      rd(HPDC_ADDR_CONTROL);
      `CHK("control", 8'h00, s)
      rd(HPDC_ADDR_STATUS);
      `CHK("status", 8'h0E, s)
      rd(3'h3);
      `CHK("unmapped", 8'h00, s)
      wr(HPDC_ADDR_CONTROL, 8'h1C);
      rd(HPDC_ADDR_CONTROL);
      `CHK("control", 8'h18, s)
      `CHK("flags", 2'h3, {hostFlagOne, hostFlagZero})
      for (int m = 0; m < 4; m++) begin
         wr(HPDC_ADDR_CONTROL, 8'(m << 5));
         rd(HPDC_ADDR_STATUS);
         `CHK("dmaMode", m != 0, s[HPDC_STAT_DMA])
      end
      // interrupt mode, host to dsp with a stalled receiver
      wr(HPDC_ADDR_CONTROL, 8'h02);
      tick(2);
      `CHK("request", 1'b0, hostRequestN)
      wrWord(24'h12_3456);
      wrWord(24'h9A_BCDE);
      tick(3);
      `CHK("rxData", 24'h12_3456, dspRxData)
      `CHK("rxValid", 1'b1, dspRxValid)
      `CHK("request", 1'b1, hostRequestN)
      dspRxReady = 1'b1;
      tick(1);
      dspRxReady = 1'b0;
      tick(3);
      `CHK("rxData", 24'h9A_BCDE, dspRxData)
      `CHK("request", 1'b0, hostRequestN)
      // interrupt mode, dsp to host until the buffer refuses
      wr(HPDC_ADDR_CONTROL, 8'h01);
      tick(2);
      `CHK("request", 1'b1, hostRequestN)
      foreach (words[k]) push(words[k]);
      tick(2);
      `CHK("txReady", 1'b0, dspTxReady)
      `CHK("request", 1'b0, hostRequestN)
      foreach (words[k]) begin
         rdWord(w);
         `CHK("hostWord", words[k], w)
      end
      tick(2);
      `CHK("request", 1'b1, hostRequestN)
      // dma 24-bit host to dsp; size changed, so initialise
      wr(HPDC_ADDR_CONTROL, 8'h22);
      wr(HPDC_ADDR_CONTROL, 8'hA2);
      tick(2);
      `CHK("request", 1'b0, hostRequestN)
      `CHK("rxValid", 1'b0, dspRxValid)
      host.dma(3, 24'h11_2233, w);
      tick(2);
      `CHK("dmaWord", 24'h11_2233, dspRxData)
      dspRxReady = 1'b1;
      host.dma(1, 24'h00_0044, w);
      wr(HPDC_ADDR_CONTROL, 8'hA2);
      rd(HPDC_ADDR_CONTROL);
      `CHK("initHeld", 1'b1, s[HPDC_BIT_INIT])
      host.dma(2, 24'h00_5566, w);
      tick(2);
      rd(HPDC_ADDR_CONTROL);
      `CHK("initDone", 1'b0, s[HPDC_BIT_INIT])
      dspRxReady = 1'b0;
      host.dma(3, 24'h77_8899, w);
      tick(2);
      `CHK("dmaWord", 24'h77_8899, dspRxData)
      // dma 8-bit dsp to host, circular on the low byte
      wr(HPDC_ADDR_CONTROL, 8'h61);
      wr(HPDC_ADDR_CONTROL, 8'hE1);
      push(24'h12_34AA);
      push(24'h56_78BB);
      tick(2);
      `CHK("request", 1'b0, hostRequestN)
      host.dma(2, 24'h00_0000, w);
      `CHK("dmaBytes", 16'hAABB, w[15:0])
      wr(HPDC_ADDR_CONTROL, 8'h23);
      tick(3);
      `CHK("request", 1'b1, hostRequestN)
      // vector acknowledge, then soft reset
      wr(HPDC_ADDR_CONTROL, 8'h1B);
      host.dma(1, 24'h00_0000, w);
      `CHK("vectorAcks", 1, vackCnt)
      softResetN = 1'b0;
      tick(1);
      softResetN = 1'b1;
      rd(HPDC_ADDR_CONTROL);
      `CHK("control", 8'h00, s)
      `CHK("flags", 2'h0, {hostFlagOne, hostFlagZero})
      endSim();
   end
endmodule // testbench
